// ### verilog/vlts_pkg.sv
// What this block does
// R1 - 60 Hz reference: offset 06H, 347H, flag set
// R2 - 60 Hz first field line n uses entry n
// R3 - 60 Hz second field 265-286 use entries 2-23
// R4 - 50 Hz reference: offset 03H, 347H, flag clear
// R5 - 50 Hz: second field 319-336 use 6-23
// R6 - Lines outside entry range use entry 24
// R7 - Upper nibble field one, lower nibble field two
// R8 - Entry 24 holds until next field begins
// R9 - Codes 6 and 15 component, others raw
// R10 - Entries 2-24 writable at 41H to 57H
// R11 - Drive raw and type controls at line start
package vlts_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_ENTRY_FIRST = 8'h41;
  localparam logic [7:0] ADDR_ENTRY_LAST  = 8'h57;
  localparam logic [7:0] ADDR_HORIZONTAL_PIXEL_OFFSET_LOW    = 8'h59;
  localparam logic [7:0] ADDR_VERTICAL_LINE_OFFSET_LOW    = 8'h5A;
  localparam logic [7:0] ADDR_OFF_HIGH    = 8'h5B;

  // Field positions in the combined high register
  localparam int FIELD_OFFSET_FLAG_BIT     = 7;
  localparam int VOFF8_BIT    = 4;
  localparam int HORIZONTAL_PIXEL_OFFSET_HI_MSB  = 2;

  // Entry numbering
  localparam int ENTRY_COUNT  = 23;
  localparam logic [4:0] ENTRY_MIN   = 5'h02;
  localparam logic [4:0] ENTRY_FINAL = 5'h18;

  // Reset values: 50 Hz reference setting, component video everywhere
  localparam logic [7:0]  ENTRY_RESET = 8'hFF;
  localparam logic [10:0] HORIZONTAL_PIXEL_OFFSET_RESET  = 11'h347;
  localparam logic [8:0]  VERTICAL_LINE_OFFSET_RESET  = 9'h003;
  localparam logic        FIELD_OFFSET_FLAG_RESET  = 1'b0;

  // Reference vertical offsets; a deviation shifts the line mapping
  localparam logic [11:0] VERTICAL_LINE_OFFSET_REF_60 = 12'h006;
  localparam logic [11:0] VERTICAL_LINE_OFFSET_REF_50 = 12'h003;

  // Second field line displacement against the first field
  localparam logic [11:0] FIELD2_SHIFT_60 = 12'h107;
  localparam logic [11:0] FIELD2_SHIFT_50 = 12'h139;

  // Data type codes giving component output
  localparam logic [3:0] CODE_COMP_VBI    = 4'h6;
  localparam logic [3:0] CODE_COMP_ACTIVE = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Controls toward scaler and slicer
  typedef struct packed {
    logic [3:0] dataType;
    logic       setRaw;
    logic       vbiLine;
  } vlts_line_ctrl_t;

  // Register bus request
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vlts_reg_req_t;

  // True when an address hits the entry table
  function automatic logic vlts_is_entry(input logic [7:0] addr);
    vlts_is_entry = (addr >= ADDR_ENTRY_FIRST) && (addr <= ADDR_ENTRY_LAST);
  endfunction

endpackage

// ### verilog/vlts_type_decode.sv
`timescale 1ns/1ns
module vlts_type_decode
  import vlts_pkg::*;
(
  input  wire logic [7:0]      entryValue,
  input  wire logic            secondField,
  output vlts_line_ctrl_t      lineCtrl
);

  logic [3:0] code;

  // Nibble choice by field identity
  assign code = secondField ? entryValue[3:0] : entryValue[7:4]; // R7

  // Only the two component codes avoid raw samples
  always_comb
  begin
    lineCtrl.dataType = code;
    lineCtrl.setRaw   = (code != CODE_COMP_VBI) && (code != CODE_COMP_ACTIVE); // R9
    lineCtrl.vbiLine  = (code != CODE_COMP_ACTIVE);
  end

endmodule

// ### verilog/vbi_line_type_selector.sv
`timescale 1ns/1ns
module vbi_line_type_selector
  import vlts_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire vlts_reg_req_t   regReq,
  output logic [7:0]           regRdata,
  output logic                 regRvalid,
  input  wire logic [9:0]      lineNumber,
  input  wire logic            secondField,
  input  wire logic [10:0]     pixelCount,
  output logic [3:0]           vbiTypeSelect,
  output logic                 setRaw,
  output logic                 vbiLine,
  output logic                 lineStart
);

  logic [7:0]  lineControlEntry [0:ENTRY_COUNT-1];
  logic [10:0] horizontalPixelOffset;
  logic [8:0]  verticalLineOffset;
  logic        fieldOffsetFlag;
  logic [4:0]  entryIndex;
  logic [4:0]  next_entryIndex;
  logic [11:0] lineShift;
  logic [11:0] relLine;
  logic [7:0]  selEntry;
  logic        selField;
  logic        next_lineStart;
  logic        lineLatched;
  vlts_line_ctrl_t decoded;

  ////////////////////////////////////////////////////////////////////////////
  // Table slot of an entry address; slot 0 holds entry 2, slot 22 entry 24.
  // Callers check the address range first, so the cut never drops a carry.
  function automatic logic [4:0] entrySlot(input logic [7:0] addr);
    entrySlot = 5'(addr - ADDR_ENTRY_FIRST);
  endfunction

  // Field step plus the slide of the vertical offset against the reference
  // of the chosen standard. Worked modulo 4096: an offset below the
  // reference wraps, and the line subtraction undoes the wrap, so the mapping slides as usual.
  function automatic logic [11:0] fieldShift(input logic       flag60,
                                             input logic       second,
                                             input logic [8:0] vertical_line_offset);
    logic [11:0] step;
    logic [11:0] refOffset;
    step      = flag60 ? FIELD2_SHIFT_60 : FIELD2_SHIFT_50;
    refOffset = flag60 ? VERTICAL_LINE_OFFSET_REF_60 : VERTICAL_LINE_OFFSET_REF_50;
    if (!second)
      step = 12'h000;
    fieldShift = step + {3'b000, vertical_line_offset} - refOffset;
  endfunction

  // Entry number for a relative line; anything outside 2..23, wrapped
  // negative values included, falls on the final entry
  function automatic logic [4:0] entryFor(input logic [11:0] rel);
    if (rel[11] || rel < 12'(ENTRY_MIN) || rel >= 12'(ENTRY_FINAL))
      entryFor = ENTRY_FINAL;
    else
      entryFor = rel[4:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Entry table writes; index 0 holds entry 2. A write lands on the next
  // edge, so a read of the same entry in that cycle returns the old value.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < ENTRY_COUNT; i++)
        lineControlEntry[i] <= ENTRY_RESET;
    end
    else if (regReq.write && vlts_is_entry(regReq.addr))
    begin
      lineControlEntry[entrySlot(regReq.addr)] <= regReq.wdata; // R10
    end
  end

  // Offset registers; reset to the 50 Hz reference setting.
  // Reserved bits of the high byte are dropped on write and read as zero.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      horizontalPixelOffset <= HORIZONTAL_PIXEL_OFFSET_RESET;
      verticalLineOffset    <= VERTICAL_LINE_OFFSET_RESET;
      fieldOffsetFlag       <= FIELD_OFFSET_FLAG_RESET; // R4
    end
    else if (regReq.write)
    begin
      case (regReq.addr)
        ADDR_HORIZONTAL_PIXEL_OFFSET_LOW: horizontalPixelOffset[7:0] <= regReq.wdata;
        ADDR_VERTICAL_LINE_OFFSET_LOW: verticalLineOffset[7:0]    <= regReq.wdata;
        ADDR_OFF_HIGH:
        begin
          fieldOffsetFlag                 <= regReq.wdata[FIELD_OFFSET_FLAG_BIT];
          verticalLineOffset[8]           <= regReq.wdata[VOFF8_BIT];
          horizontalPixelOffset[10:8]     <= regReq.wdata[HORIZONTAL_PIXEL_OFFSET_HI_MSB:0];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read port, one cycle after the strobe; unmapped reads zero.
  // Read data holds until the next read, so software may sample it late.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      regRdata  <= 8'h00;
      regRvalid <= 1'b0;
    end
    else
    begin
      regRvalid <= regReq.read;
      if (regReq.read)
      begin
        if (vlts_is_entry(regReq.addr))
          regRdata <= lineControlEntry[entrySlot(regReq.addr)];
        else
        begin
          case (regReq.addr)
            ADDR_HORIZONTAL_PIXEL_OFFSET_LOW: regRdata <= horizontalPixelOffset[7:0];
            ADDR_VERTICAL_LINE_OFFSET_LOW: regRdata <= verticalLineOffset[7:0];
            ADDR_OFF_HIGH: regRdata <= {fieldOffsetFlag, 2'b00, verticalLineOffset[8],
                                        1'b0, horizontalPixelOffset[10:8]};
            default:       regRdata <= 8'h00;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line to entry mapping. The flag picks the line standard: set gives the
  // 263-line field step, clear the 313-line step. A vertical offset away from
  // the reference slides the whole mapping by the difference.
  always_comb
  begin
    lineShift = fieldShift(fieldOffsetFlag, secondField, verticalLineOffset); // R1 R3 R4 R5
    relLine   = {2'b00, lineNumber} - lineShift; // R2
  end

  // Entry 24 covers every line outside the table, to the end of the field
  always_comb
  begin
    next_entryIndex = entryFor(relLine); // R6 R8
  end

  // Line start is the pixel position set by the horizontal offset. An offset
  // beyond the line length never matches, and the controls then keep their
  // last value until the offset is brought back into range.
  assign next_lineStart = (pixelCount == horizontalPixelOffset);

  ////////////////////////////////////////////////////////////////////////////
  // Index and field are latched at the start pixel, so the decoder counters
  // may move on at once without upsetting the current line
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      entryIndex <= ENTRY_FINAL;
      selField   <= 1'b0;
    end
    else if (next_lineStart)
    begin
      entryIndex <= next_entryIndex; // R11
      selField   <= secondField;
    end
  end

  // Table entry for the latched index; entry 24 is the last array word
  assign selEntry = lineControlEntry[5'(entryIndex - ENTRY_MIN)];

  // Nibble pick by field and raw decode of the latched entry
  vlts_type_decode u_decode (
    .entryValue  (selEntry),
    .secondField (selField),
    .lineCtrl    (decoded)
  );

  // Line start pulse, delayed one edge so it rises together with the
  // controls that it announces
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lineLatched <= 1'b0;
      lineStart   <= 1'b0;
    end
    else
    begin
      lineLatched <= next_lineStart;
      lineStart   <= lineLatched; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controls load only one edge after the latch and then hold for the whole
  // line: a table write mid-line waits for the next line start, so software
  // may rewrite entries at any time. Reset shows the field-one code of the
  // reset entry 24, which is a component code.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vbiTypeSelect <= ENTRY_RESET[7:4];
      setRaw        <= 1'b0;
      vbiLine       <= 1'b0;
    end
    else if (lineLatched)
    begin
      vbiTypeSelect <= decoded.dataType; // R11
      setRaw        <= decoded.setRaw;   // R9
      vbiLine       <= decoded.vbiLine;
    end
  end

endmodule

// ### dv/vlts_sel_chk.sv
`timescale 1ns/1ns
module vlts_sel_chk
  import vlts_pkg::*;
(
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire vlts_reg_req_t regReq,
  input wire logic [7:0]    regRdata,
  input wire logic          regRvalid,
  input wire logic [3:0]    vbiTypeSelect,
  input wire logic          setRaw,
  input wire logic          vbiLine,
  input wire logic          lineStart
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Holes in the map: below the table, the gap at 58H, above 5BH
  wire unmapped = regReq.addr < 8'h41 || regReq.addr == 8'h58 || regReq.addr > 8'h5B;
  ////////////////////////////////////////////////////////////////////////////
  a_read_valid: assert property (regReq.read |=> regRvalid) else $error("no read answer");
  a_no_stray_valid: assert property (!regReq.read |=> !regRvalid) else $error("stray valid");
  a_unmapped_zero: assert property (regReq.read && unmapped |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_high_reserved: assert property (regReq.read && regReq.addr == 8'h5B |=> regRdata[6:5] == 2'b00 && !regRdata[3])
    else $error("reserved bits set");
  a_rdata_hold: assert property (!regReq.read |=> $stable(regRdata)) else $error("read data moved");
  a_raw_decode: assert property (lineStart |-> setRaw == !(vbiTypeSelect inside {4'h6, 4'hF}))
    else $error("raw flag wrong");
  a_type_line: assert property (lineStart |-> vbiLine == (vbiTypeSelect != 4'hF)) else $error("vbi flag wrong");
  a_start_pulse: assert property (lineStart |=> !lineStart) else $error("line start too long");
  // First edge after reset compares with a sample taken in reset, so skip it
  a_ctrl_hold: assert property (!lineStart && !$past(sys_rst) |-> $stable(vbiTypeSelect))
    else $error("type moved mid line");
  c_raw_line: cover property (lineStart && setRaw);
  c_comp_line: cover property (lineStart && !setRaw);
  c_read: cover property (regRvalid);
endmodule
bind vbi_line_type_selector vlts_sel_chk i_vlts_sel_chk (.clk, .sys_rst, .regReq, .regRdata, .regRvalid,
  .vbiTypeSelect, .setRaw, .vbiLine, .lineStart);

// ### dv/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t %h %h", $time, a, b); end end
module tb_top
  import vlts_pkg::*;
;
  logic          clk;
  logic          sys_rst;
  vlts_reg_req_t regReq;
  logic [7:0]    regRdata;
  logic          regRvalid;
  logic [9:0]    lineNumber;
  logic          secondField;
  logic [10:0]   pixelCount;
  logic [3:0]    vbiTypeSelect;
  logic          setRaw;
  logic          vbiLine;
  logic          lineStart;
  int            miscompares;
  int            checks;
  vbi_line_type_selector i_vbi_line_type_selector (.clk, .sys_rst, .regReq, .regRdata, .regRvalid,
    .lineNumber, .secondField, .pixelCount, .vbiTypeSelect, .setRaw, .vbiLine, .lineStart);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Entry pattern: both nibbles differ, codes 6 and F both appear
  function automatic logic [7:0] ev(input int i);
    ev = {i[3:0], 4'hF - i[3:0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq.write = 1'b1;
    regReq.addr = a;
    regReq.wdata = d;
    @(negedge clk);
    regReq.write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    regReq.read = 1'b1;
    regReq.addr = a;
    @(negedge clk);
    regReq.read = 1'b0;
    `CHK(regRvalid, 1'b1)
    `CHK(regRdata, exp)
  endtask
  // Controls appear one edge after the start pixel is sampled
  task automatic ln(input int n, input bit fld, input int step);
    int         idx;
    logic [7:0] e;
    logic [3:0] c;
    idx = n - (fld ? step : 0);
    if (idx < 2 || idx > 23)
      idx = 24;
    e = ev(idx);
    c = fld ? e[3:0] : e[7:4];
    @(negedge clk);
    lineNumber = n[9:0];
    secondField = fld;
    pixelCount = 11'h347;
    @(negedge clk);
    pixelCount = 11'h000;
    @(posedge clk);
    #1;
    `CHK(lineStart, 1'b1)
    `CHK(vbiTypeSelect, c)
    `CHK(setRaw, !(c == 4'h6 || c == 4'hF))
    `CHK(vbiLine, (c != 4'hF))
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    `CHK(vbiTypeSelect, 4'hF)
    rd(8'h41, 8'hFF);
    rd(8'h59, 8'h47);
    rd(8'h5A, 8'h03);
    rd(8'h5B, 8'h03);
    wr(8'h58, 8'hAA);
    rd(8'h58, 8'h00);
    $display("test_regs done");
  endtask
  task automatic test_50();
    int l[8] = '{1, 6, 15, 24, 318, 319, 336, 337};
    for (int i = 2; i <= 24; i++)
      wr(8'h3F + i[7:0], ev(i));
    rd(8'h57, ev(24));
    for (int k = 0; k < 8; k++)
      ln(l[k], k > 3, 313);
    $display("test_50 done");
  endtask
  task automatic test_60();
    int l[8] = '{2, 21, 23, 24, 264, 265, 286, 287};
    wr(8'h5A, 8'h06);
    wr(8'h5B, 8'h83);
    rd(8'h5B, 8'h83);
    for (int k = 0; k < 8; k++)
      ln(l[k], k > 3, 263);
    $display("test_60 done");
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    regReq = '0;
    lineNumber = '0;
    secondField = 1'b0;
    pixelCount = '0;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    test_regs();
    test_50();
    test_60();
    wrap_up();
  end
  // Whole run needs under 200 cycles
  initial
  begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
